// >>> hw/msil_consts.vh
// constants for the meter status and information list block
`ifndef MSIL_CONSTS_VH
`define MSIL_CONSTS_VH
// register offsets on the plain register port
`define MSIL_ADDR_W 4
`define MSIL_OFF_INST 4'h0
`define MSIL_OFF_FERR 4'h1
`define MSIL_OFF_CTRL 4'h2
`define MSIL_OFF_MENU 4'h3
// control register fields
`define MSIL_CTRL_PARAM 0
`define MSIL_CTRL_CLR 1
// installation word digit positions (low bit of each nibble)
`define MSIL_DIG_TAMPER 0
`define MSIL_DIG_ROTATE 4
`define MSIL_DIG_PHASE 8
`define MSIL_DIG_REVP 12
`define MSIL_DIG_CINT 16
`define MSIL_DIG_IMAX 20
`define MSIL_DIG_UNDER 24
`define MSIL_DIG_OVER 28
// function error flag positions
`define MSIL_FE_DATA 2
`define MSIL_FE_PAR 8
`define MSIL_FE_SET 9
`define MSIL_FE_CODE 10
`define MSIL_FE_ADJ 15
// reset values
`define MSIL_WORD_ZERO 32'h0000_0000
`define MSIL_NIBBLE_ZERO 4'h0
// width of one installation word digit
`define MSIL_DIGIT_W 4
// press thresholds in milliseconds
`define MSIL_SHORT_MS 2000
`define MSIL_LONG_MS 5000
`define MSIL_CLK_KHZ 10000
// display menu states
`define MSIL_ST_OPER 3'h0
`define MSIL_ST_ENTRY 3'h1
`define MSIL_ST_INST 3'h2
`define MSIL_ST_REG 3'h3
`define MSIL_ST_END 3'h4
`endif

// >>> hw/msil_top.v
// meter status words, function error flags and information list menu
// How it works
// - in the list, a press under 2 s advances to the next item
// - a press of 2 s or more in the list skips historical items ahead
// - at entry, a 2..5 s press enters; first item is installation word
// - at end item, under 2 s returns to first register; over 5 s exits
// - installation faults are recorded in the installation word, shown on display
// - installation conditions come from instantaneous measurement inputs
// - no fault present reads as 0000_0000
// - tamper digit: 1 meter cover, 2 terminal cover, 4 magnetic field
// - rotating-field digit: 1 lost neutral, 2 wrong phase sequence
// - phase-failure digit: 1,2,4 for lines one..three, 8 auxiliary supply
// - reverse power and current interruption digits: 1,2,4 per line
// - over-current, under 80% and over 115% digits: 1,2,4 per line
// - function error word holds five flags as an eight digit word
// - supply-loss data checksum failure sets value 4 in lowest digit
// - parameter, settings, program checksum set 1,2,4 in third digit
// - calibration checksum failure sets 8 in fourth digit
// - function error word is output to display and read-out
// - clear command works only in parametrisation mode
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "msil_consts.vh"
module msil_top #(
  parameter SHORT_CYC = (`MSIL_SHORT_MS * `MSIL_CLK_KHZ),
  parameter LONG_CYC = (`MSIL_LONG_MS * `MSIL_CLK_KHZ),
  parameter REG_COUNT = 8,
  parameter HIST_SKIP = 4
) (
  // clock, reset, enable
  input wire clk_in,
  input wire resetn_in,
  input wire ce_in,
  // call-up button, high while pressed
  input wire button_in,
  // instantaneous measurement conditions, one bit per condition
  input wire [2:0] tamper_in,
  input wire neutral_lost_in,
  input wire phase_seq_bad_in,
  input wire [2:0] phase_fail_in,
  input wire aux_fail_in,
  input wire [2:0] rev_power_in,
  input wire [2:0] cur_int_in,
  input wire [2:0] over_cur_in,
  input wire [2:0] under_volt_in,
  input wire [2:0] over_volt_in,
  // checksum failure pulses
  input wire data_cks_fail_in,
  input wire par_cks_fail_in,
  input wire set_cks_fail_in,
  input wire code_cks_fail_in,
  input wire adj_cks_fail_in,
  // register port
  input wire [`MSIL_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  // display path
  output reg [2:0] menu_state_out,
  output reg [7:0] menu_item_out,
  output reg [31:0] display_word_out,
  output reg operation_display_out,
  output reg [31:0] readout_ferr_out
);

  localparam CNT_W = 32;

  wire [31:0] inst_reg;
  wire [31:0] ferr_reg;
  reg param_mode_reg;
  reg [2:0] state_reg;
  reg [7:0] item_reg;
  reg [CNT_W-1:0] press_reg;
  reg btn_reg;
  reg [2:0] state_next;
  reg [7:0] item_next;
  wire flag_data;
  wire flag_par;
  wire flag_set;
  wire flag_code;
  wire flag_adj;
  wire release_evt;
  wire is_short;
  wire is_mid;
  wire is_long;
  wire clr_cmd;

  // installation word: one registered digit per category, not sticky
  msil_digit #(
    .FLAG_W(3)
  ) u_msil_digit_tamper (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in(tamper_in),
    .digit_out(inst_reg[`MSIL_DIG_TAMPER +: `MSIL_DIGIT_W])
  );
  msil_digit #(
    .FLAG_W(2)
  ) u_msil_digit_rotate (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in({phase_seq_bad_in, neutral_lost_in}),
    .digit_out(inst_reg[`MSIL_DIG_ROTATE +: `MSIL_DIGIT_W])
  );
  msil_digit #(
    .FLAG_W(4)
  ) u_msil_digit_phase (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in({aux_fail_in, phase_fail_in}),
    .digit_out(inst_reg[`MSIL_DIG_PHASE +: `MSIL_DIGIT_W])
  );
  msil_digit #(
    .FLAG_W(3)
  ) u_msil_digit_revp (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in(rev_power_in),
    .digit_out(inst_reg[`MSIL_DIG_REVP +: `MSIL_DIGIT_W])
  );
  msil_digit #(
    .FLAG_W(3)
  ) u_msil_digit_cint (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in(cur_int_in),
    .digit_out(inst_reg[`MSIL_DIG_CINT +: `MSIL_DIGIT_W])
  );
  msil_digit #(
    .FLAG_W(3)
  ) u_msil_digit_imax (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in(over_cur_in),
    .digit_out(inst_reg[`MSIL_DIG_IMAX +: `MSIL_DIGIT_W])
  );
  msil_digit #(
    .FLAG_W(3)
  ) u_msil_digit_under (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in(under_volt_in),
    .digit_out(inst_reg[`MSIL_DIG_UNDER +: `MSIL_DIGIT_W])
  );
  msil_digit #(
    .FLAG_W(3)
  ) u_msil_digit_over (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .flags_in(over_volt_in),
    .digit_out(inst_reg[`MSIL_DIG_OVER +: `MSIL_DIGIT_W])
  );

  // sticky checksum flags, cleared only by an accepted clear command
  msil_flag u_msil_flag_data (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .set_in(data_cks_fail_in),
    .clr_in(clr_cmd),
    .flag_out(flag_data)
  );
  msil_flag u_msil_flag_par (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .set_in(par_cks_fail_in),
    .clr_in(clr_cmd),
    .flag_out(flag_par)
  );
  msil_flag u_msil_flag_set (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .set_in(set_cks_fail_in),
    .clr_in(clr_cmd),
    .flag_out(flag_set)
  );
  msil_flag u_msil_flag_code (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .set_in(code_cks_fail_in),
    .clr_in(clr_cmd),
    .flag_out(flag_code)
  );
  msil_flag u_msil_flag_adj (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .set_in(adj_cks_fail_in),
    .clr_in(clr_cmd),
    .flag_out(flag_adj)
  );

  // function error word from the five flags, other bits read zero
  assign ferr_reg = ({31'h0000_0000, flag_data} << `MSIL_FE_DATA) |
    ({31'h0000_0000, flag_par} << `MSIL_FE_PAR) |
    ({31'h0000_0000, flag_set} << `MSIL_FE_SET) |
    ({31'h0000_0000, flag_code} << `MSIL_FE_CODE) |
    ({31'h0000_0000, flag_adj} << `MSIL_FE_ADJ);

  assign clr_cmd = wr_in && (addr_in == `MSIL_OFF_CTRL) && wdata_in[`MSIL_CTRL_CLR] && param_mode_reg;

  // press classification on release
  assign release_evt = btn_reg && !button_in;
  assign is_short = press_reg < SHORT_CYC;
  assign is_long = press_reg > LONG_CYC;
  assign is_mid = !is_short && !is_long;

  // parametrisation mode bit of the control register
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      param_mode_reg <= 1'b0;
    end else if (ce_in) begin
      if (wr_in && (addr_in == `MSIL_OFF_CTRL)) begin
        param_mode_reg <= wdata_in[`MSIL_CTRL_PARAM];
      end
    end
  end

  // press duration counter
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      btn_reg <= 1'b0;
      press_reg <= {CNT_W{1'b0}};
    end else if (ce_in) begin
      btn_reg <= button_in;
      if (!button_in) begin
        press_reg <= {CNT_W{1'b0}};
      end else if (press_reg != {CNT_W{1'b1}}) begin
        press_reg <= press_reg + 1'b1;
      end
    end
  end

  // menu next state
  always @* begin
    state_next = state_reg;
    item_next = item_reg;
    if (release_evt) begin
      case (state_reg)
        `MSIL_ST_OPER: begin
          if (is_short) begin
            state_next = `MSIL_ST_ENTRY;
          end
        end
        `MSIL_ST_ENTRY: begin
          if (is_mid) begin
            state_next = `MSIL_ST_INST;
            item_next = 8'h00;
          end else if (is_long) begin
            state_next = `MSIL_ST_OPER;
          end
        end
        `MSIL_ST_INST, `MSIL_ST_REG: begin
          if (is_short) begin
            item_next = item_reg + 8'h01;
          end else begin
            item_next = item_reg + HIST_SKIP[7:0];
          end
          if (item_next >= REG_COUNT[7:0]) begin
            state_next = `MSIL_ST_END;
            item_next = REG_COUNT[7:0];
          end else begin
            state_next = `MSIL_ST_REG;
          end
        end
        `MSIL_ST_END: begin
          if (is_short) begin
            state_next = `MSIL_ST_INST;
            item_next = 8'h00;
          end else if (is_long) begin
            state_next = `MSIL_ST_OPER;
          end
        end
        default: begin
          state_next = `MSIL_ST_OPER;
        end
      endcase
    end
  end

  // menu state and display outputs
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= `MSIL_ST_OPER;
      item_reg <= 8'h00;
      menu_state_out <= `MSIL_ST_OPER;
      menu_item_out <= 8'h00;
      display_word_out <= `MSIL_WORD_ZERO;
      operation_display_out <= 1'b1;
      readout_ferr_out <= `MSIL_WORD_ZERO;
    end else if (ce_in) begin
      state_reg <= state_next;
      item_reg <= item_next;
      menu_state_out <= state_next;
      menu_item_out <= item_next;
      operation_display_out <= (state_next == `MSIL_ST_OPER);
      readout_ferr_out <= ferr_reg;
      if (state_next == `MSIL_ST_INST) begin
        display_word_out <= inst_reg;
      end else if (state_next == `MSIL_ST_REG && item_next == 8'h01) begin
        display_word_out <= ferr_reg;
      end else begin
        display_word_out <= `MSIL_WORD_ZERO;
      end
    end
  end

  // register read port, data one cycle after strobe
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= `MSIL_WORD_ZERO;
    end else if (ce_in) begin
      if (rd_in) begin
        case (addr_in)
          `MSIL_OFF_INST: rdata_out <= inst_reg;
          `MSIL_OFF_FERR: rdata_out <= ferr_reg;
          `MSIL_OFF_CTRL: rdata_out <= {31'h0000_0000, param_mode_reg};
          `MSIL_OFF_MENU: rdata_out <= {21'h00_0000, state_reg, item_reg};
          default: rdata_out <= `MSIL_WORD_ZERO;
        endcase
      end else begin
        rdata_out <= `MSIL_WORD_ZERO;
      end
    end
  end

endmodule // msil_top

// one installation digit: condition flags of a category, registered as a nibble
module msil_digit #(
  parameter FLAG_W = 3
) (
  // clock, reset, enable
  input wire clk_in,
  input wire resetn_in,
  input wire ce_in,
  // instantaneous conditions of this category, bit n for code 2**n
  input wire [FLAG_W-1:0] flags_in,
  // nibble as it stands in the installation word
  output reg [`MSIL_DIGIT_W-1:0] digit_out
);

  wire [`MSIL_DIGIT_W-1:0] digit_next;

  // unused high code bits read zero; codes of one category combine bitwise
  generate
    if (FLAG_W < `MSIL_DIGIT_W) begin : g_pad
      assign digit_next = {{(`MSIL_DIGIT_W-FLAG_W){1'b0}}, flags_in};
    end else begin : g_full
      assign digit_next = flags_in[`MSIL_DIGIT_W-1:0];
    end
  endgenerate

  // follows the inputs every enabled cycle, so a cleared condition drops out
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      digit_out <= `MSIL_NIBBLE_ZERO;
    end else if (ce_in) begin
      digit_out <= digit_next;
    end
  end

endmodule // msil_digit

// one sticky error flag: a set pulse wins over a clear in the same cycle
module msil_flag #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  // clock, reset, enable
  input wire clk_in,
  input wire resetn_in,
  input wire ce_in,
  // failure pulse and accepted clear command
  input wire set_in,
  input wire clr_in,
  // flag as it stands in the function error word
  output reg flag_out
);

  // drops only on an accepted clear, never when the failure goes away
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flag_out <= RESET_VAL;
    end else if (ce_in) begin
      flag_out <= set_in | (flag_out & ~clr_in);
    end
  end

endmodule // msil_flag

// >>> sim/msil_btn_model.sv
// call-up button model: holds the button for a given number of cycles
`timescale 1ns/1ns
module msil_btn_model (
  input wire clk_in,
  output reg button_out
);
  initial button_out = 1'b0;
  // press n cycles, change only after a rising edge
  task press(input integer n);
    begin
      @(posedge clk_in) button_out <= 1'b1;
      repeat (n) @(posedge clk_in);
      button_out <= 1'b0;
    end
  endtask
endmodule // msil_btn_model

// >>> sim/msil_top_asserts.sv
// checker for status words, error flags, register port and menu
`timescale 1ns/1ns
module msil_top_asserts (
  input wire clk_in, resetn_in, button_in, wr_in, rd_in,
  input wire [2:0] tamper_in, phase_fail_in, rev_power_in, cur_int_in, over_cur_in, under_volt_in, over_volt_in,
  input wire neutral_lost_in, phase_seq_bad_in, aux_fail_in, data_cks_fail_in,
  input wire par_cks_fail_in, set_cks_fail_in, code_cks_fail_in, adj_cks_fail_in,
  input wire [3:0] addr_in,
  input wire [31:0] rdata_out, readout_ferr_out,
  input wire [2:0] menu_state_out,
  input wire operation_display_out
);
  // expected installation word and checksum flag pattern from the inputs
  wire [31:0] iw = {1'b0, over_volt_in, 1'b0, under_volt_in, 1'b0, over_cur_in, 1'b0, cur_int_in, 1'b0,
    rev_power_in, aux_fail_in, phase_fail_in, 2'b00, phase_seq_bad_in, neutral_lost_in, 1'b0, tamper_in};
  wire [31:0] fw = {16'h0000, adj_cks_fail_in, 4'h0, code_cks_fail_in, set_cks_fail_in, par_cks_fail_in, 8'h00};
  wire clr = wr_in && addr_in == 4'h2;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_iw; rd_in && addr_in == 4'h0 && $stable(iw) |=> rdata_out == $past(iw); endproperty
  a_iw: assert property (p_iw) else $error("installation word mismatch");
  property p_data; data_cks_fail_in |-> ##[1:2] readout_ferr_out[2]; endproperty
  a_data: assert property (p_data) else $error("data checksum flag not set");
  property p_fset; fw != 32'h0000_0000 |-> ##2 (readout_ferr_out & $past(fw, 2)) == $past(fw, 2); endproperty
  a_fset: assert property (p_fset) else $error("checksum flag not set");
  property p_stk; !clr && !$past(clr)
    |=> (readout_ferr_out & $past(readout_ferr_out)) == $past(readout_ferr_out); endproperty
  a_stk: assert property (p_stk) else $error("error flag dropped");
  property p_rd0; !rd_in |=> rdata_out == 32'h0000_0000; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside read");
  property p_unm; rd_in && addr_in > 4'h3 |=> rdata_out == 32'h0000_0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_oper; operation_display_out == (menu_state_out == 3'h0); endproperty
  a_oper: assert property (p_oper) else $error("operation display flag wrong");
  property p_rel; $changed(menu_state_out) |-> !$past(button_in) && $past(button_in, 2); endproperty
  a_rel: assert property (p_rel) else $error("menu moved without release");
  c_end: cover property (menu_state_out == 3'h4);
  c_err: cover property (rd_in && addr_in == 4'h1 ##1 rdata_out != 32'h0000_0000);
  c_exit: cover property ($rose(operation_display_out));
endmodule // msil_top_asserts
bind msil_top msil_top_asserts u_msil_top_asserts (.*);

// >>> sim/tb_top.sv
// self-checking bench: status words, error flags, register port, menu
`timescale 1ns/1ns
`include "msil_consts.vh"
module tb_top;
  reg clk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, ce_in = 1'b1;
  reg [23:0] m = 24'h00_0000;
  reg [4:0] f = 5'h0;
  reg [3:0] addr_in = 4'h0;
  reg [31:0] wdata_in = 32'h0000_0000, ew = 32'h0000_0000, got;
  reg [15:0] lf = 16'h3d57;
  integer n_mismatch = 0, compares = 0, cyc = 0, i;
  wire button_in, operation_display_out;
  wire [31:0] rdata_out, display_word_out, readout_ferr_out;
  wire [2:0] menu_state_out;
  wire [7:0] menu_item_out;
  initial forever #50 clk_in = ~clk_in;
  msil_btn_model u_msil_btn_model (.clk_in(clk_in), .button_out(button_in));
  msil_top #(.SHORT_CYC(20), .LONG_CYC(50)) u_msil_top (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .button_in(button_in), .tamper_in(m[2:0]), .neutral_lost_in(m[3]), .phase_seq_bad_in(m[4]),
    .phase_fail_in(m[7:5]), .aux_fail_in(m[8]), .rev_power_in(m[11:9]), .cur_int_in(m[14:12]),
    .over_cur_in(m[17:15]), .under_volt_in(m[20:18]), .over_volt_in(m[23:21]), .data_cks_fail_in(f[0]),
    .par_cks_fail_in(f[1]), .set_cks_fail_in(f[2]), .code_cks_fail_in(f[3]), .adj_cks_fail_in(f[4]),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .menu_state_out(menu_state_out), .menu_item_out(menu_item_out), .display_word_out(display_word_out),
    .operation_display_out(operation_display_out), .readout_ferr_out(readout_ferr_out));
  // expectation helpers
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [31:0] iw(input [23:0] v);
    iw = {1'b0, v[23:21], 1'b0, v[20:18], 1'b0, v[17:15], 1'b0, v[14:12], 1'b0, v[11:9], v[8:5], 2'b00, v[4:3], 1'b0, v[2:0]};
  endfunction
  function [31:0] fb(input integer k);
    fb = (k == 0) ? 32'h0000_0004 : (k == 4) ? 32'h0000_8000 : (32'h0000_0100 << (k - 1));
  endfunction
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
      @(posedge clk_in) wr_in <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk_in) {rd_in, addr_in} <= {1'b1, a};
      @(posedge clk_in) rd_in <= 1'b0;
      #1 got = rdata_out;
    end
  endtask
  task btn(input integer n, input [2:0] s, input [7:0] it);
    begin
      u_msil_btn_model.press(n);
      repeat (3) @(posedge clk_in);
      chk("state", {29'h0, s}, {29'h0, menu_state_out});
      if (s == `MSIL_ST_INST || s == `MSIL_ST_REG) chk("item", {24'h0, it}, {24'h0, menu_item_out});
    end
  endtask
  task finish_test;
    begin
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(4'h0);
    chk("inst", 32'h0000_0000, got);
    for (i = 0; i < 24; i = i + 1) begin
      lf = nx(lf);
      @(posedge clk_in) m <= (i == 0) ? 24'hff_ffff : {lf[7:0], lf};
      rd(4'h0);
      chk("inst", iw(m), got);
    end
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clk_in) f <= 5'h01 << i;
      @(posedge clk_in) f <= 5'h00;
      ew = ew | fb(i);
      rd(4'h1);
      chk("ferr", ew, got);
    end
    chk("ferr_ro", ew, readout_ferr_out);
    wr(4'h2, 32'h0000_0002);
    wr(4'h0, 32'hffff_ffff);
    rd(4'h1);
    chk("ferr", ew, got);
    rd(4'h0);
    chk("inst", iw(m), got);
    rd(4'h9);
    chk("unmap", 32'h0000_0000, got);
    wr(4'h2, 32'h0000_0001);
    wr(4'h2, 32'h0000_0003);
    rd(4'h1);
    chk("ferr", 32'h0000_0000, got);
    wr(4'h2, 32'h0000_0000);
    @(posedge clk_in) f <= 5'h10;
    @(posedge clk_in) f <= 5'h00;
    btn(5, `MSIL_ST_ENTRY, 8'h00);
    btn(30, `MSIL_ST_INST, 8'h00);
    chk("disp", iw(m), display_word_out);
    btn(5, `MSIL_ST_REG, 8'h01);
    chk("disp", 32'h0000_8000, display_word_out);
    btn(60, `MSIL_ST_REG, 8'h05);
    btn(5, `MSIL_ST_REG, 8'h06);
    btn(5, `MSIL_ST_REG, 8'h07);
    btn(5, `MSIL_ST_END, 8'h00);
    btn(5, `MSIL_ST_INST, 8'h00);
    btn(60, `MSIL_ST_REG, 8'h04);
    btn(60, `MSIL_ST_END, 8'h00);
    btn(60, `MSIL_ST_OPER, 8'h00);
    chk("oper", 32'h0000_0001, {31'h0, operation_display_out});
    // a whole press while the clock enable is low leaves the menu in place
    @(posedge clk_in) ce_in <= 1'b0;
    u_msil_btn_model.press(5);
    @(posedge clk_in) ce_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("frozen", {29'h0, `MSIL_ST_OPER}, {29'h0, menu_state_out});
    btn(5, `MSIL_ST_ENTRY, 8'h00);
    finish_test;
  end
endmodule // tb_top
